//--- core/tlic_pkg.sv
// Constants for the two-level interrupt controller: register map, fields, resets, vectors.
//
// Contract
// - With priority on, high requests vector to 0008h and low requests to 0018h.
// - A qualified high request preempts a running low-level service routine.
// - Every source owns a flag bit, an enable bit and a priority bit.
// - Two-level operation is active only while the priority mode enable is set.
// - In priority mode control bit 7 globally enables high-priority sources.
// - In priority mode control bit 6 globally enables low-priority sources.
// - Flag, enable and applicable global enable all set vectors at once by priority.
// - Priority mode enable resets cleared; then priority bits have no effect.
// - In compatibility mode bit 6 gates peripherals and bit 7 gates everything.
// - In compatibility mode every accepted interrupt vectors to 0008h.
// - Acceptance clears the global enable of the level being entered.
// - Low requests stay pending while a high service routine runs.
// - Acceptance tells the core to push the return address and load the vector.
// - Return from interrupt sets again the global enable cleared on entry.
// - Pin and port-change events reach the vector in three to four cycles.
// - Flags set on their event regardless of any enable bit.
// - In priority mode bit 6 set enables low-priority peripheral interrupts.
// - External pin flags stay set until software clears them.
package tlic_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VEC_W = 16;
    localparam int N_PIN = 4;
    localparam int N_PORT = 4;
    localparam int N_EXT = 5;
    localparam int N_PER = 8;

    localparam logic [ADDR_W-1:0] OFF_RESET_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL_B = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL_C = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PER_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PER_EN = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PER_PRI = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;

    localparam int BIT_PRIO_EN = 7;
    localparam int BIT_HIGH_GE = 7;
    localparam int BIT_LOW_GE = 6;
    localparam int B_EDGE_LSB = 0;
    localparam int C_FLAG_LSB = 0;
    localparam int C_EN_LSB = 8;
    localparam int C_PRI_LSB = 16;
    localparam int ST_IN_HIGH = 0;
    localparam int ST_IN_LOW = 1;

    localparam logic RST_PRIO_EN = 1'b0;
    localparam logic RST_GLOBAL_EN = 1'b0;
    localparam logic [N_PIN-1:0] RST_EDGE = 4'hf;
    localparam logic [N_EXT-1:0] RST_EXT_EN = 5'h00;
    localparam logic [N_EXT-1:0] RST_EXT_PRI = 5'h1f;
    localparam logic [N_PER-1:0] RST_PER_EN = 8'h00;
    localparam logic [N_PER-1:0] RST_PER_PRI = 8'hff;

    localparam logic [VEC_W-1:0] VEC_HIGH = 16'h0008;
    localparam logic [VEC_W-1:0] VEC_LOW = 16'h0018;
endpackage

//--- core/tlic_pin_edge.sv
// Pin synchroniser with selectable edge detection, one pin per instance.
`timescale 1ns/1ps
module tlic_pin_edge (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    input wire logic any_edge,
    input wire logic rise_sel,
    output logic evt
);
    logic sync1;
    logic sync2;
    logic prev;
    logic [2:0] warm;

    // The first stage feeds only the second; edges are judged after it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Edges are ignored until the delay line holds real pin samples, so a pin that
    // idles high does not look like a fresh edge just after reset.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            warm <= '0;
        end else begin
            warm <= {warm[1:0], 1'b1};
        end
    end

    always_comb begin
        if (!warm[2]) begin
            evt = 1'b0;
        end else if (any_edge) begin
            evt = sync2 ^ prev;
        end else if (rise_sel) begin
            evt = sync2 & ~prev;
        end else begin
            evt = ~sync2 & prev;
        end
    end
endmodule

//--- core/tlic_flag_reg.sv
// Software-writable event flags where a hardware set beats a same-cycle software clear.
`timescale 1ns/1ps
module tlic_flag_reg #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] set,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] q
);
    // Flags are only cleared by a write, never by vectoring.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (wr) begin
            q <= set | wdata;
        end else begin
            q <= set | q;
        end
    end
endmodule

//--- core/tlic_top.sv
// Two-level interrupt controller with an APB register file and a core vector port.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module tlic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tlic_pkg::ADDR_W-1:0] paddr,
    input wire logic [tlic_pkg::DATA_W-1:0] pwdata,
    output logic [tlic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tlic_pkg::N_PIN-1:0] external_irq_pins,
    input wire logic [tlic_pkg::N_PORT-1:0] port_change_pins,
    input wire logic [tlic_pkg::N_PER-1:0] periph_event,
    input wire logic return_from_isr_instruction,
    output logic irq_take,
    output logic [tlic_pkg::VEC_W-1:0] vector_addr,
    output logic in_service_high,
    output logic in_service_low
);
    localparam int NP = tlic_pkg::N_PIN + tlic_pkg::N_PORT;

    logic priority_mode_enable;
    logic high_level_global_enable;
    logic low_level_global_enable;
    logic [tlic_pkg::N_PIN-1:0] edge_rise;
    logic [tlic_pkg::N_EXT-1:0] ext_en;
    logic [tlic_pkg::N_EXT-1:0] ext_pri;
    logic [tlic_pkg::N_EXT-1:0] ext_flag;
    logic [tlic_pkg::N_PER-1:0] per_en;
    logic [tlic_pkg::N_PER-1:0] per_pri;
    logic [tlic_pkg::N_PER-1:0] per_flag;
    logic [NP-1:0] all_pins;
    logic [NP-1:0] pin_evt;
    logic [tlic_pkg::N_EXT-1:0] ext_set;
    logic [tlic_pkg::N_EXT-1:0] ext_pend;
    logic [tlic_pkg::N_PER-1:0] per_pend;
    logic access;
    logic setup_done;
    logic wr_reset_ctrl;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_ctrl_c;
    logic wr_per_flag;
    logic wr_per_en;
    logic wr_per_pri;
    logic mapped;
    logic [tlic_pkg::DATA_W-1:0] rd_mux;
    logic req_compat;
    logic req_high;
    logic req_low;
    logic req_any;
    logic ret_high;
    logic ret_low;

    // APB: pready rises one cycle into the access phase; writes land on the edge after that.
    assign setup_done = psel & penable & ~pready;
    assign access = psel & penable & pready;
    assign wr_reset_ctrl = access & pwrite & (paddr == tlic_pkg::OFF_RESET_CTRL);
    assign wr_ctrl_a = access & pwrite & (paddr == tlic_pkg::OFF_CTRL_A);
    assign wr_ctrl_b = access & pwrite & (paddr == tlic_pkg::OFF_CTRL_B);
    assign wr_ctrl_c = access & pwrite & (paddr == tlic_pkg::OFF_CTRL_C);
    assign wr_per_flag = access & pwrite & (paddr == tlic_pkg::OFF_PER_FLAG);
    assign wr_per_en = access & pwrite & (paddr == tlic_pkg::OFF_PER_EN);
    assign wr_per_pri = access & pwrite & (paddr == tlic_pkg::OFF_PER_PRI);

    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        case (paddr)
            tlic_pkg::OFF_RESET_CTRL: begin
                rd_mux[tlic_pkg::BIT_PRIO_EN] = priority_mode_enable;
            end
            tlic_pkg::OFF_CTRL_A: begin
                rd_mux[tlic_pkg::BIT_HIGH_GE] = high_level_global_enable;
                rd_mux[tlic_pkg::BIT_LOW_GE] = low_level_global_enable;
            end
            tlic_pkg::OFF_CTRL_B: begin
                rd_mux[tlic_pkg::B_EDGE_LSB +: tlic_pkg::N_PIN] = edge_rise;
            end
            tlic_pkg::OFF_CTRL_C: begin
                rd_mux[tlic_pkg::C_FLAG_LSB +: tlic_pkg::N_EXT] = ext_flag;
                rd_mux[tlic_pkg::C_EN_LSB +: tlic_pkg::N_EXT] = ext_en;
                rd_mux[tlic_pkg::C_PRI_LSB +: tlic_pkg::N_EXT] = ext_pri;
            end
            tlic_pkg::OFF_PER_FLAG: begin
                rd_mux[tlic_pkg::N_PER-1:0] = per_flag;
            end
            tlic_pkg::OFF_PER_EN: begin
                rd_mux[tlic_pkg::N_PER-1:0] = per_en;
            end
            tlic_pkg::OFF_PER_PRI: begin
                rd_mux[tlic_pkg::N_PER-1:0] = per_pri;
            end
            tlic_pkg::OFF_STATUS: begin
                rd_mux[tlic_pkg::ST_IN_HIGH] = in_service_high;
                rd_mux[tlic_pkg::ST_IN_LOW] = in_service_low;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_done;
            pslverr <= setup_done & ~mapped;
            if (setup_done && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Plain configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_mode_enable <= tlic_pkg::RST_PRIO_EN;
            edge_rise <= tlic_pkg::RST_EDGE;
            ext_en <= tlic_pkg::RST_EXT_EN;
            ext_pri <= tlic_pkg::RST_EXT_PRI;
            per_en <= tlic_pkg::RST_PER_EN;
            per_pri <= tlic_pkg::RST_PER_PRI;
        end else begin
            if (wr_reset_ctrl) begin
                priority_mode_enable <= pwdata[tlic_pkg::BIT_PRIO_EN];
            end
            if (wr_ctrl_b) begin
                edge_rise <= pwdata[tlic_pkg::B_EDGE_LSB +: tlic_pkg::N_PIN];
            end
            if (wr_ctrl_c) begin
                ext_en <= pwdata[tlic_pkg::C_EN_LSB +: tlic_pkg::N_EXT];
                ext_pri <= pwdata[tlic_pkg::C_PRI_LSB +: tlic_pkg::N_EXT];
            end
            if (wr_per_en) begin
                per_en <= pwdata[tlic_pkg::N_PER-1:0];
            end
            if (wr_per_pri) begin
                per_pri <= pwdata[tlic_pkg::N_PER-1:0];
            end
        end
    end

    // Pins: external lines use their edge select, port-change lines react to any edge.
    assign all_pins = {port_change_pins, external_irq_pins};

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pin
            tlic_pin_edge u_edge (
                .clk(pclk),
                .rstn(presetn),
                .pin(all_pins[gi]),
                .any_edge(gi >= tlic_pkg::N_PIN),
                .rise_sel(gi < tlic_pkg::N_PIN ? edge_rise[gi % tlic_pkg::N_PIN] : 1'b1),
                .evt(pin_evt[gi])
            );
        end
    endgenerate

    assign ext_set = {|pin_evt[NP-1:tlic_pkg::N_PIN], pin_evt[tlic_pkg::N_PIN-1:0]};

    tlic_flag_reg #(.W(tlic_pkg::N_EXT)) u_ext_flags (
        .clk(pclk),
        .rstn(presetn),
        .set(ext_set),
        .wr(wr_ctrl_c),
        .wdata(pwdata[tlic_pkg::C_FLAG_LSB +: tlic_pkg::N_EXT]),
        .q(ext_flag)
    );

    tlic_flag_reg #(.W(tlic_pkg::N_PER)) u_per_flags (
        .clk(pclk),
        .rstn(presetn),
        .set(periph_event),
        .wr(wr_per_flag),
        .wdata(pwdata[tlic_pkg::N_PER-1:0]),
        .q(per_flag)
    );

    // Qualification. Pin and port-change sources are core sources, the rest peripherals.
    assign ext_pend = ext_flag & ext_en;
    assign per_pend = per_flag & per_en;
    assign req_compat = ~priority_mode_enable & high_level_global_enable
        & ((|ext_pend) | (low_level_global_enable & (|per_pend)));
    assign req_high = priority_mode_enable & high_level_global_enable
        & ((|(ext_pend & ext_pri)) | (|(per_pend & per_pri)));
    // Low requests also need the high enable, and wait out any high routine.
    assign req_low = priority_mode_enable & high_level_global_enable
        & low_level_global_enable & ~in_service_high
        & ((|(ext_pend & ~ext_pri)) | (|(per_pend & ~per_pri)));
    assign req_any = req_compat | req_high | req_low;
    assign ret_high = return_from_isr_instruction & in_service_high;
    assign ret_low = return_from_isr_instruction & ~in_service_high & in_service_low;

    // Acceptance is a one-cycle request to the core to push and jump.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_take <= 1'b0;
            vector_addr <= tlic_pkg::VEC_HIGH;
        end else begin
            irq_take <= req_any;
            if (req_compat || req_high) begin
                vector_addr <= tlic_pkg::VEC_HIGH;
            end else if (req_low) begin
                vector_addr <= tlic_pkg::VEC_LOW;
            end
        end
    end

    // Hardware entry and return override a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_level_global_enable <= tlic_pkg::RST_GLOBAL_EN;
            low_level_global_enable <= tlic_pkg::RST_GLOBAL_EN;
        end else if (req_compat || req_high) begin
            high_level_global_enable <= 1'b0;
            if (wr_ctrl_a) begin
                low_level_global_enable <= pwdata[tlic_pkg::BIT_LOW_GE];
            end
        end else if (req_low) begin
            low_level_global_enable <= 1'b0;
            if (wr_ctrl_a) begin
                high_level_global_enable <= pwdata[tlic_pkg::BIT_HIGH_GE];
            end
        end else if (ret_high) begin
            high_level_global_enable <= 1'b1;
        end else if (ret_low) begin
            low_level_global_enable <= 1'b1;
        end else if (return_from_isr_instruction) begin
            high_level_global_enable <= 1'b1;
        end else if (wr_ctrl_a) begin
            high_level_global_enable <= pwdata[tlic_pkg::BIT_HIGH_GE];
            low_level_global_enable <= pwdata[tlic_pkg::BIT_LOW_GE];
        end
    end

    // Nesting record: a high routine may sit on top of a low one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_service_high <= 1'b0;
            in_service_low <= 1'b0;
        end else if (req_compat || req_high) begin
            in_service_high <= 1'b1;
        end else if (req_low) begin
            in_service_low <= 1'b1;
        end else if (ret_high) begin
            in_service_high <= 1'b0;
        end else if (ret_low) begin
            in_service_low <= 1'b0;
        end
    end

    property p_vec_compat;
        @(posedge pclk) disable iff (!presetn)
        (irq_take && !$past(priority_mode_enable)) |-> vector_addr == tlic_pkg::VEC_HIGH;
    endproperty
    a_vec_compat: assert property (p_vec_compat) else $error("compat vector wrong");

    property p_vec_low;
        @(posedge pclk) disable iff (!presetn)
        (req_low && !req_high) |=> irq_take && vector_addr == tlic_pkg::VEC_LOW;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("low vector not taken");

    property p_preempt;
        @(posedge pclk) disable iff (!presetn)
        (in_service_low && req_high) |=> irq_take && vector_addr == tlic_pkg::VEC_HIGH;
    endproperty
    a_preempt: assert property (p_preempt) else $error("high did not preempt low");

    property p_low_blocked;
        @(posedge pclk) disable iff (!presetn)
        (in_service_high && !ret_high) |=> !(irq_take && vector_addr == tlic_pkg::VEC_LOW);
    endproperty
    a_low_blocked: assert property (p_low_blocked) else $error("low taken in high");

    property p_clear_on_entry;
        @(posedge pclk) disable iff (!presetn)
        irq_take |-> (vector_addr == tlic_pkg::VEC_LOW) ? !low_level_global_enable
            : !high_level_global_enable;
    endproperty
    a_clear_on_entry: assert property (p_clear_on_entry) else $error("enable kept");

    property p_return;
        @(posedge pclk) disable iff (!presetn)
        (ret_high && !req_any) |=> high_level_global_enable && !in_service_high;
    endproperty
    a_return: assert property (p_return) else $error("return did not re-enable");

    property p_high_first;
        @(posedge pclk) disable iff (!presetn)
        (req_high && (|(per_pend & ~per_pri) || |(ext_pend & ~ext_pri)))
            |=> vector_addr == tlic_pkg::VEC_HIGH;
    endproperty
    a_high_first: assert property (p_high_first) else $error("low beat high");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        (periph_event != '0) |=> (per_flag & $past(periph_event)) == $past(periph_event);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        !wr_ctrl_c |=> (ext_flag & $past(ext_flag)) == $past(ext_flag);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("pin flag dropped");

    property p_prio_ignored;
        @(posedge pclk) disable iff (!presetn)
        (!priority_mode_enable && !in_service_low) |=> !in_service_low;
    endproperty
    a_prio_ignored: assert property (p_prio_ignored) else $error("priority used in compat");

    property p_record_low;
        @(posedge pclk) disable iff (!presetn)
        (irq_take && vector_addr == tlic_pkg::VEC_LOW) |-> in_service_low;
    endproperty
    a_record_low: assert property (p_record_low) else $error("low level not recorded");
endmodule

//--- bench/tlic_core_model.sv
// Behavioural processor core: program counter, return stack and return requests.
`timescale 1ns/1ps
module tlic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_take,
    input wire logic [tlic_pkg::VEC_W-1:0] vector_addr,
    input wire logic ret_req,
    output logic return_from_isr_instruction,
    output logic [tlic_pkg::VEC_W-1:0] pc
);
    logic [tlic_pkg::VEC_W-1:0] stack[$];

    // A return with an empty stack is never issued, as real service code cannot do that.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= 16'h0100;
            return_from_isr_instruction <= 1'b0;
            stack.delete();
        end else begin
            return_from_isr_instruction <= 1'b0;
            if (irq_take) begin
                stack.push_back(pc);
                pc <= vector_addr;
            end else if (ret_req && stack.size() > 0) begin
                return_from_isr_instruction <= 1'b1;
                pc <= stack.pop_back();
            end else begin
                pc <= pc + 16'h0001;
            end
        end
    end
endmodule

//--- bench/test_two_level_interrupt_control.sv
// Self-checking bench for the two-level interrupt controller with a core model.
`timescale 1ns/1ps
module test_two_level_interrupt_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ret_req, ret_pulse;
    logic [7:0] paddr, periph_event, rnd;
    logic [31:0] pwdata, prdata;
    logic [3:0] external_irq_pins, port_change_pins;
    logic irq_take, in_service_high, in_service_low;
    logic [15:0] vector_addr, pc;
    logic [32:0] exp_rd[$];
    logic [15:0] exp_vec[$];
    int failures, checked, seed, n;

    tlic_top u_tlic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_irq_pins(external_irq_pins),
        .port_change_pins(port_change_pins), .periph_event(periph_event),
        .return_from_isr_instruction(ret_pulse), .irq_take(irq_take),
        .vector_addr(vector_addr), .in_service_high(in_service_high),
        .in_service_low(in_service_low));
    tlic_core_model u_tlic_core_model (.pclk(pclk), .presetn(presetn), .irq_take(irq_take),
        .vector_addr(vector_addr), .ret_req(ret_req), .return_from_isr_instruction(ret_pulse),
        .pc(pc));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Results are compared here as they appear, oldest expectation first.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 33'h1_dead_beef);
        end
        if (irq_take === 1'b1) begin
            check({17'h0_0000, vector_addr}, exp_vec.size() ? {17'h0_0000, exp_vec.pop_front()}
                : 33'h1_dead_beef);
        end
    end

    // Control registers change by bus writes, and the global enables also on interrupt entry and return.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic pulse(input logic [7:0] v);
        periph_event <= v;
        @(posedge pclk);
        periph_event <= 8'h00;
        repeat (6) @(posedge pclk);
    endtask

    task automatic ret();
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, ret_req} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        periph_event = 8'h00;
        external_irq_pins = 4'h0;
        port_change_pins = 4'h0;
        failures = 0;
        checked = 0;
        seed = 44562;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(tlic_pkg::OFF_RESET_CTRL, 33'h0_0000_0000);
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_0000);
        rd(tlic_pkg::OFF_CTRL_B, 33'h0_0000_000f);
        rd(tlic_pkg::OFF_CTRL_C, 33'h0_001f_0000);
        rd(tlic_pkg::OFF_PER_PRI, 33'h0_0000_00ff);
        rd(tlic_pkg::OFF_STATUS, 33'h0_0000_0000);
        rd(8'h20, 33'h1_0000_0000);
        rnd = 8'($random(seed));
        periph_event <= rnd;
        @(posedge pclk);
        periph_event <= 8'h00;
        repeat (2) @(posedge pclk);
        rd(tlic_pkg::OFF_PER_FLAG, {25'h000_0000, rnd});
        wr(tlic_pkg::OFF_PER_FLAG, 32'h0000_0000);
        // Compatibility mode: the low priority bit is ignored and bit 6 gates peripherals.
        wr(tlic_pkg::OFF_PER_EN, 32'h0000_0001);
        wr(tlic_pkg::OFF_PER_PRI, 32'h0000_0000);
        wr(tlic_pkg::OFF_CTRL_A, 32'h0000_0080);
        pulse(8'h01);
        exp_vec.push_back(tlic_pkg::VEC_HIGH);
        wr(tlic_pkg::OFF_CTRL_A, 32'h0000_00c0);
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_0040);
        wr(tlic_pkg::OFF_PER_FLAG, 32'h0000_0000);
        ret();
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_00c0);
        wr(tlic_pkg::OFF_CTRL_A, 32'h0000_0000);
        // Priority mode: source 0 high, source 1 low, both pending together.
        wr(tlic_pkg::OFF_RESET_CTRL, 32'h0000_0080);
        wr(tlic_pkg::OFF_PER_PRI, 32'h0000_0001);
        wr(tlic_pkg::OFF_PER_EN, 32'h0000_0003);
        pulse(8'h03);
        exp_vec.push_back(tlic_pkg::VEC_HIGH);
        wr(tlic_pkg::OFF_CTRL_A, 32'h0000_00c0);
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_0040);
        rd(tlic_pkg::OFF_STATUS, 33'h0_0000_0001);
        wr(tlic_pkg::OFF_PER_FLAG, 32'h0000_0002);
        exp_vec.push_back(tlic_pkg::VEC_LOW);
        ret();
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_0080);
        rd(tlic_pkg::OFF_STATUS, 33'h0_0000_0002);
        exp_vec.push_back(tlic_pkg::VEC_HIGH);
        pulse(8'h01);
        rd(tlic_pkg::OFF_STATUS, 33'h0_0000_0003);
        wr(tlic_pkg::OFF_PER_FLAG, 32'h0000_0000);
        ret();
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_0080);
        ret();
        rd(tlic_pkg::OFF_CTRL_A, 33'h0_0000_00c0);
        rd(tlic_pkg::OFF_STATUS, 33'h0_0000_0000);
        // Pin and port-change sources, high priority by default.
        wr(tlic_pkg::OFF_CTRL_C, 32'h001f_1100);
        // The third pass selects the falling edge on pin 0 and lets the pin drop.
        for (int s = 0; s < 3; s++) begin
            if (s == 2) wr(tlic_pkg::OFF_CTRL_B, 32'h0000_000e);
            exp_vec.push_back(tlic_pkg::VEC_HIGH);
            if (s == 0) external_irq_pins[0] <= 1'b1;
            else if (s == 1) port_change_pins[0] <= 1'b1;
            else external_irq_pins[0] <= 1'b0;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
                #1;
            end while (irq_take !== 1'b1 && n < 20);
            check(33'(n >= 3 && n <= 4), 33'h0_0000_0001);
            @(posedge pclk);
            rd(tlic_pkg::OFF_CTRL_C, s == 1 ? 33'h0_001f_1110 : 33'h0_001f_1101);
            wr(tlic_pkg::OFF_CTRL_C, 32'h001f_1100);
            ret();
        end
        repeat (4) @(posedge pclk);
        check(33'(exp_vec.size() + exp_rd.size()), 33'h0_0000_0000);
        complete_run();
    end
endmodule
